//--- tdm_codec_pkg.sv
`default_nettype none
// ==========================================================
// tdm codec package
package tdm_codec_pkg;

   // ==========================================================
   // serial link timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCLK_PERIOD_NS = 320;
   localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF_CYCLES - 1);

   // ==========================================================
   // frame geometry
   localparam logic [3:0] WORD_LAST_BIT = 4'hF;
   localparam logic [4:0] LAST_SLOT_LONG = 5'h1F;
   localparam logic [4:0] LAST_SLOT_SHORT = 5'h0F;
   localparam logic [3:0] SUB_CONTROL = 4'h0;
   localparam logic [3:0] SUB_PLAY_LEFT = 4'h1;
   localparam logic [3:0] SUB_PLAY_RIGHT = 4'h2;
   localparam logic [3:0] TX_BASE_SHARED = 4'h3;
   localparam logic [3:0] TX_BASE_SPLIT = 4'h0;
   localparam logic [1:0] TX_POS_STATUS = 2'h0;
   localparam logic [1:0] TX_POS_LEFT = 2'h1;
   localparam logic [1:0] TX_POS_RIGHT = 2'h2;
   localparam logic [1:0] TX_POS_NONE = 2'h3;

   // ==========================================================
   // register indexes
   localparam logic [3:0] IDX_PLAYBACK = 4'h9;
   localparam logic [3:0] IDX_PIN_CONTROL = 4'hA;
   localparam logic [3:0] IDX_UNUSED_ELEVEN = 4'hB;
   localparam logic [3:0] IDX_FRAME_SLOT_CONFIG = 4'hC;
   localparam logic [3:0] IDX_LOOPBACK_MIX_CONTROL = 4'hD;
   localparam logic [3:0] IDX_UNUSED_FOURTEEN = 4'hE;
   localparam logic [3:0] IDX_UNUSED_FIFTEEN = 4'hF;

   // ==========================================================
   // field positions and reset values
   localparam int PLAYBACK_ENABLE_BIT = 0;
   localparam int EXT_CTRL_HI_BIT = 7;
   localparam int EXT_CTRL_LO_BIT = 6;
   localparam int FRAME_SIZE_BIT = 7;
   localparam int TX_SLOT_BIT = 6;
   localparam int MIX_ENABLE_BIT = 0;
   localparam int MIX_ATT_MSB = 7;
   localparam int MIX_ATT_LSB = 2;
   localparam logic [7:0] PLAYBACK_RESET = 8'h00;
   localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
   localparam logic [7:0] FRAME_SLOT_RESET = 8'h00;
   localparam logic [7:0] MIX_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PIN_CONTROL_MASK = 8'hC0;
   localparam logic [7:0] FRAME_SLOT_MASK = 8'hC0;
   localparam logic [7:0] MIX_CONTROL_MASK = 8'hFD;
   localparam logic [7:0] PLAYBACK_MASK = 8'h01;

   // ==========================================================
   // attenuation fractions of a 6 dB octave, q8
   localparam logic [8:0] ATT_FRAC_0 = 9'h100;
   localparam logic [8:0] ATT_FRAC_1 = 9'h0D7;
   localparam logic [8:0] ATT_FRAC_2 = 9'h0B5;
   localparam logic [8:0] ATT_FRAC_3 = 9'h099;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic clear_overrange_flag;
      logic config_change_flag;
      logic readback_request;
      logic reserved;
      logic [3:0] register_index;
      logic [7:0] data;
   } ctrl_word_s;

   typedef struct packed {
      logic signed [15:0] left;
      logic signed [15:0] right;
   } sample_s;

endpackage : tdm_codec_pkg
`default_nettype wire

//--- tdm_codec_serial_port.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// capture fifo
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [CW-1:0] count_ff;
   logic [CW-1:0] nxt_count;
   logic ready_ff;
   logic valid_ff;
   wire push = in_valid & ready_ff;
   wire pop = out_ready & valid_ff;

   assign nxt_count = push && !pop ? count_ff + 1'b1 : (pop && !push ? count_ff - 1'b1 : count_ff);
   assign in_ready = ready_ff;
   assign out_valid = valid_ff;
   assign out_data = mem[rd_ptr_ff];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   // flags registered from the next count so they stay exact
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         ready_ff <= 1'b0;
         valid_ff <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff == LAST_PTR ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff == LAST_PTR ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= nxt_count;
         ready_ff <= nxt_count != FULL_COUNT;
         valid_ff <= nxt_count != '0;
      end
   end
endmodule : sample_fifo

// ==========================================================
// serial port top
module tdm_codec_serial_port #(
   parameter int FIFO_DEPTH = 8,
   parameter logic [3:0] CHIP_ID = 4'h5 // arbitrary value
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic serial_in_line,
   output logic serial_clk,
   output logic frame_sync,
   output logic serial_out_line,
   output logic serial_out_oe,
   output logic ext_ctrl_pin_hi,
   output logic ext_ctrl_pin_lo,
   input wire tdm_codec_pkg::sample_s adc_sample,
   input wire logic adc_valid,
   output logic adc_ready,
   input wire logic dac_req,
   output tdm_codec_pkg::sample_s dac_sample,
   output logic dac_valid
);

   // ==========================================================
   // arithmetic helpers
   function automatic logic signed [15:0] attenuate(input logic signed [15:0] x, input logic [5:0] a);
      logic signed [15:0] sh;
      logic signed [9:0] frac;
      logic signed [25:0] prod;
      sh = x >>> a[5:2];
      case (a[1:0])
         2'h0: frac = $signed({1'b0, tdm_codec_pkg::ATT_FRAC_0});
         2'h1: frac = $signed({1'b0, tdm_codec_pkg::ATT_FRAC_1});
         2'h2: frac = $signed({1'b0, tdm_codec_pkg::ATT_FRAC_2});
         default: frac = $signed({1'b0, tdm_codec_pkg::ATT_FRAC_3});
      endcase
      prod = sh * frac;
      attenuate = prod[23:8];
   endfunction : attenuate

   function automatic logic signed [15:0] sat_add(input logic signed [15:0] a, input logic signed [15:0] b);
      logic signed [16:0] s;
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15]) begin
         sat_add = s[16] ? 16'sh8000 : 16'sh7FFF;
      end else begin
         sat_add = s[15:0];
      end
   endfunction : sat_add

   // which of the three transmit words a sub-slot carries
   function automatic logic [1:0] tx_pos(input logic [3:0] sub, input logic split);
      logic [3:0] base;
      base = split ? tdm_codec_pkg::TX_BASE_SPLIT : tdm_codec_pkg::TX_BASE_SHARED;
      if (sub == base) begin
         tx_pos = tdm_codec_pkg::TX_POS_STATUS;
      end else if (sub == base + 4'h1) begin
         tx_pos = tdm_codec_pkg::TX_POS_LEFT;
      end else if (sub == base + 4'h2) begin
         tx_pos = tdm_codec_pkg::TX_POS_RIGHT;
      end else begin
         tx_pos = tdm_codec_pkg::TX_POS_NONE;
      end
   endfunction : tx_pos

   // ==========================================================
   // state
   logic in_meta_ff;
   logic in_sync_ff;
   logic [2:0] div_cnt_ff;
   logic sclk_ff;
   logic [3:0] bit_cnt_ff;
   logic [4:0] slot_cnt_ff;
   logic frame_sync_ff;
   logic [15:0] tx_shift_ff;
   logic tx_bit_ff;
   logic tx_oe_ff;
   logic [15:0] rx_shift_ff;
   tdm_codec_pkg::ctrl_word_s ctrl_ff;
   logic [7:0] playback_reg_ff;
   logic [7:0] pin_reg_ff;
   logic [7:0] frame_reg_ff;
   logic [7:0] mix_reg_ff;
   logic frame_size_select_ff;
   logic transmit_slot_select_ff;
   tdm_codec_pkg::sample_s play_ff;
   logic play_new_ff;
   tdm_codec_pkg::sample_s tx_sample_ff;
   tdm_codec_pkg::sample_s last_cap_ff;
   logic overrun_ff;
   logic underrun_ff;
   tdm_codec_pkg::sample_s dac_ff;
   logic dac_valid_ff;
   logic ext_hi_ff;
   logic ext_lo_ff;

   // ==========================================================
   // bit clock and counters
   wire half_end = div_cnt_ff == tdm_codec_pkg::SCLK_HALF_LAST;
   wire rise_ev = half_end & ~sclk_ff;
   wire fall_ev = half_end & sclk_ff;
   wire word_end = bit_cnt_ff == tdm_codec_pkg::WORD_LAST_BIT;
   wire [4:0] last_slot = frame_size_select_ff ? tdm_codec_pkg::LAST_SLOT_SHORT
                                               : tdm_codec_pkg::LAST_SLOT_LONG;
   wire frame_end = slot_cnt_ff == last_slot;
   wire [4:0] nxt_slot = frame_end ? 5'h00 : slot_cnt_ff + 5'h01;
   wire slot_start = fall_ev & word_end;
   wire frame_wrap = slot_start & frame_end;
   // pending setup only counts from the wrap onward
   wire nxt_split = frame_wrap ? frame_reg_ff[tdm_codec_pkg::TX_SLOT_BIT] : transmit_slot_select_ff;
   wire [1:0] nxt_pos = tx_pos(nxt_slot[3:0], nxt_split);

   // ==========================================================
   // receive decode
   wire rx_done = rise_ev & word_end;
   wire [15:0] rx_word = {rx_shift_ff[14:0], in_sync_ff};
   tdm_codec_pkg::ctrl_word_s rx_ctrl;
   assign rx_ctrl = rx_word;
   wire [3:0] rx_sub = slot_cnt_ff[3:0];
   wire ctrl_rx = rx_done & (rx_sub == tdm_codec_pkg::SUB_CONTROL);
   wire left_rx = rx_done & (rx_sub == tdm_codec_pkg::SUB_PLAY_LEFT);
   wire right_rx = rx_done & (rx_sub == tdm_codec_pkg::SUB_PLAY_RIGHT);
   wire [3:0] widx = rx_ctrl.register_index;
   // only a word with its own change flag set writes the frame register
   wire wr_frame = ctrl_rx & (widx == tdm_codec_pkg::IDX_FRAME_SLOT_CONFIG) & rx_ctrl.config_change_flag;
   wire wr_pin = ctrl_rx & (widx == tdm_codec_pkg::IDX_PIN_CONTROL);
   wire wr_mix = ctrl_rx & (widx == tdm_codec_pkg::IDX_LOOPBACK_MIX_CONTROL);
   wire wr_play = ctrl_rx & (widx == tdm_codec_pkg::IDX_PLAYBACK);
   wire clear_flags = ctrl_rx & rx_ctrl.clear_overrange_flag;

   // ==========================================================
   // readback and status
   wire [3:0] ridx = ctrl_ff.register_index;
   wire idx_invalid = (ridx == tdm_codec_pkg::IDX_UNUSED_ELEVEN) | (ridx == tdm_codec_pkg::IDX_UNUSED_FOURTEEN)
                      | (ridx == tdm_codec_pkg::IDX_UNUSED_FIFTEEN);
   wire [7:0] reg_val = ridx == tdm_codec_pkg::IDX_PIN_CONTROL ? pin_reg_ff
                      : ridx == tdm_codec_pkg::IDX_FRAME_SLOT_CONFIG ? frame_reg_ff
                      : ridx == tdm_codec_pkg::IDX_LOOPBACK_MIX_CONTROL ? mix_reg_ff
                      : ridx == tdm_codec_pkg::IDX_PLAYBACK ? playback_reg_ff : 8'h00;
   wire [15:0] status_word = {2'b00, ctrl_ff.readback_request, 1'b0, CHIP_ID, 6'h00, underrun_ff, overrun_ff};
   wire [15:0] readback_word = {ctrl_ff[15:8], reg_val};
   wire [15:0] first_word = ctrl_ff.readback_request && !idx_invalid ? readback_word : status_word;

   // ==========================================================
   // capture buffer and transmit word select
   tdm_codec_pkg::sample_s fifo_out;
   logic fifo_valid;
   logic fifo_ready;
   wire fifo_pop = slot_start & (nxt_pos == tdm_codec_pkg::TX_POS_STATUS);
   wire [15:0] tx_load = nxt_pos == tdm_codec_pkg::TX_POS_STATUS ? first_word
                       : nxt_pos == tdm_codec_pkg::TX_POS_LEFT ? tx_sample_ff.left
                       : tx_sample_ff.right;
   wire cap_push = adc_valid & fifo_ready;
   wire cap_overrun = adc_valid & ~fifo_ready;

   // a slow drain stalls the source through adc_ready
   sample_fifo #(
      .WIDTH($bits(tdm_codec_pkg::sample_s)),
      .DEPTH(FIFO_DEPTH)
   ) capture_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(adc_sample),
      .in_valid(adc_valid),
      .in_ready(fifo_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // ==========================================================
   // mix datapath
   wire mix_on = mix_reg_ff[tdm_codec_pkg::MIX_ENABLE_BIT];
   wire [5:0] mix_att = mix_reg_ff[tdm_codec_pkg::MIX_ATT_MSB:tdm_codec_pkg::MIX_ATT_LSB];
   wire play_on = playback_reg_ff[tdm_codec_pkg::PLAYBACK_ENABLE_BIT];
   wire play_fresh = play_on & play_new_ff;
   wire signed [15:0] play_l = play_fresh ? play_ff.left : 16'sh0000;
   wire signed [15:0] play_r = play_fresh ? play_ff.right : 16'sh0000;
   wire signed [15:0] mix_l = mix_on ? attenuate(last_cap_ff.left, mix_att) : 16'sh0000;
   wire signed [15:0] mix_r = mix_on ? attenuate(last_cap_ff.right, mix_att) : 16'sh0000;

   // ==========================================================
   // link pin sync, bit clock, framing
   // only the second flop of the input sync is read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_meta_ff <= 1'b0;
         in_sync_ff <= 1'b0;
      end else begin
         in_meta_ff <= serial_in_line;
         in_sync_ff <= in_meta_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_cnt_ff <= 3'h0;
         sclk_ff <= 1'b0;
      end else begin
         div_cnt_ff <= half_end ? 3'h0 : div_cnt_ff + 3'h1;
         sclk_ff <= sclk_ff ^ half_end;
      end
   end

   // reset parks at the last bit of the last slot so the first fall opens a frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_ff <= tdm_codec_pkg::WORD_LAST_BIT;
         slot_cnt_ff <= tdm_codec_pkg::LAST_SLOT_LONG;
         frame_sync_ff <= 1'b0;
      end else if (fall_ev) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
         if (word_end) begin
            slot_cnt_ff <= nxt_slot;
         end
         frame_sync_ff <= slot_start & frame_end;
      end
   end

   // ==========================================================
   // transmit shifter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_shift_ff <= 16'h0000;
         tx_bit_ff <= 1'b0;
         tx_oe_ff <= 1'b0;
      end else if (slot_start) begin
         tx_shift_ff <= tx_load;
         tx_bit_ff <= tx_load[15];
         tx_oe_ff <= nxt_pos != tdm_codec_pkg::TX_POS_NONE;
      end else if (fall_ev) begin
         tx_shift_ff <= {tx_shift_ff[14:0], 1'b0};
         tx_bit_ff <= tx_shift_ff[14];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_sample_ff <= '0;
      end else if (fifo_pop && fifo_valid) begin
         tx_sample_ff <= fifo_out;
      end
   end

   // ==========================================================
   // receive shifter and control words
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_shift_ff <= 16'h0000;
         ctrl_ff <= '0;
      end else if (rise_ev) begin
         rx_shift_ff <= rx_word;
         if (ctrl_rx) begin
            ctrl_ff <= rx_ctrl;
         end
      end
   end

   // indexes 11, 14, 15 decode to no write strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         playback_reg_ff <= tdm_codec_pkg::PLAYBACK_RESET;
         pin_reg_ff <= tdm_codec_pkg::PIN_CONTROL_RESET;
         frame_reg_ff <= tdm_codec_pkg::FRAME_SLOT_RESET;
         mix_reg_ff <= tdm_codec_pkg::MIX_CONTROL_RESET;
      end else begin
         if (wr_play) begin
            playback_reg_ff <= rx_ctrl.data & tdm_codec_pkg::PLAYBACK_MASK;
         end
         if (wr_pin) begin
            pin_reg_ff <= rx_ctrl.data & tdm_codec_pkg::PIN_CONTROL_MASK;
         end
         if (wr_frame) begin
            frame_reg_ff <= rx_ctrl.data & tdm_codec_pkg::FRAME_SLOT_MASK;
         end
         if (wr_mix) begin
            mix_reg_ff <= rx_ctrl.data & tdm_codec_pkg::MIX_CONTROL_MASK;
         end
      end
   end

   // active setup moves only at the frame wrap, which is also why a first-sample
   // change in a long frame waits for the following frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_size_select_ff <= 1'b0;
         transmit_slot_select_ff <= 1'b0;
      end else if (frame_wrap) begin
         frame_size_select_ff <= frame_reg_ff[tdm_codec_pkg::FRAME_SIZE_BIT];
         transmit_slot_select_ff <= frame_reg_ff[tdm_codec_pkg::TX_SLOT_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_hi_ff <= 1'b0;
         ext_lo_ff <= 1'b0;
      end else begin
         ext_hi_ff <= pin_reg_ff[tdm_codec_pkg::EXT_CTRL_HI_BIT];
         ext_lo_ff <= pin_reg_ff[tdm_codec_pkg::EXT_CTRL_LO_BIT];
      end
   end

   // ==========================================================
   // playback, capture history, dac feed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         play_ff <= '0;
         play_new_ff <= 1'b0;
      end else begin
         if (left_rx) begin
            play_ff.left <= rx_word;
         end
         if (right_rx) begin
            play_ff.right <= rx_word;
         end
         play_new_ff <= right_rx | (play_new_ff & ~dac_req);
      end
   end

   // on overrun nothing is stored, so the pre-overrun sample stays
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_cap_ff <= '0;
      end else if (cap_push) begin
         last_cap_ff <= adc_sample;
      end
   end

   // set wins over the clear carried in a control word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overrun_ff <= 1'b0;
         underrun_ff <= 1'b0;
      end else begin
         overrun_ff <= cap_overrun | (overrun_ff & ~clear_flags);
         underrun_ff <= (dac_req & play_on & ~play_new_ff) | (underrun_ff & ~clear_flags);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dac_ff <= '0;
         dac_valid_ff <= 1'b0;
      end else begin
         dac_valid_ff <= dac_req;
         if (dac_req) begin
            dac_ff.left <= sat_add(play_l, mix_l);
            dac_ff.right <= sat_add(play_r, mix_r);
         end
      end
   end

   // ==========================================================
   // outputs
   assign serial_clk = sclk_ff;
   assign frame_sync = frame_sync_ff;
   assign serial_out_line = tx_bit_ff;
   assign serial_out_oe = tx_oe_ff;
   assign ext_ctrl_pin_hi = ext_hi_ff;
   assign ext_ctrl_pin_lo = ext_lo_ff;
   assign adc_ready = fifo_ready;
   assign dac_sample = dac_ff;
   assign dac_valid = dac_valid_ff;

endmodule : tdm_codec_serial_port
`default_nettype wire

//--- tdm_codec_serial_port_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link checker
module tdm_codec_serial_port_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic frame_sync,
   input wire logic serial_out_line,
   input wire logic serial_out_oe,
   input wire logic dac_req,
   input wire logic dac_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_hi; $rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk; endproperty
   property p_lo; $fell(serial_clk) |-> !serial_clk [*4] ##1 serial_clk; endproperty
   property p_fs; $rose(frame_sync) |-> $fell(serial_clk); endproperty
   property p_fsw; $rose(frame_sync) |-> frame_sync [*8] ##1 !frame_sync; endproperty
   property p_bit; serial_out_oe && $changed(serial_out_line) |-> $fell(serial_clk); endproperty
   property p_oe; $changed(serial_out_oe) |-> $fell(serial_clk); endproperty
   property p_ans; dac_req |=> dac_valid; endproperty
   property p_one; dac_valid |-> $past(dac_req); endproperty
   a_hi: assert property (p_hi) else $error("bit clock high phase");
   a_lo: assert property (p_lo) else $error("bit clock low phase");
   a_fs: assert property (p_fs) else $error("frame sync off edge");
   a_fsw: assert property (p_fsw) else $error("frame sync width");
   a_bit: assert property (p_bit) else $error("data off edge");
   a_oe: assert property (p_oe) else $error("enable off edge");
   a_ans: assert property (p_ans) else $error("no dac answer");
   a_one: assert property (p_one) else $error("stray dac valid");
   c_fs: cover property ($rose(frame_sync));
   c_oe: cover property ($rose(serial_out_oe));
   c_dac: cover property (dac_valid);
endmodule : tdm_codec_serial_port_props
`default_nettype wire

//--- tdm_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far-side controller, follows the device's clock and sync
module tdm_link_partner (
   input wire logic clk,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic frame_sync,
   input wire logic serial_out_line,
   input wire logic [15:0] ctrl_word,
   output logic serial_in_line
);
   logic sclk_ff;
   logic [8:0] pos_ff;
   logic [15:0] shift_ff;
   logic [15:0] rx [32];
   logic [8:0] nxt_pos;
   assign nxt_pos = frame_sync ? 9'h000 : pos_ff + 9'h001;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_ff <= 1'b0;
         pos_ff <= 9'h000;
         serial_in_line <= 1'b0;
      end else begin
         sclk_ff <= serial_clk;
         if (sclk_ff && !serial_clk) begin
            pos_ff <= nxt_pos;
            // toggles in sub-slots 3 and up, sends zero in sub-slots 1 and 2, so a stale bit never passes
            if (nxt_pos[7:4] == 4'h0) begin
               serial_in_line <= ctrl_word[~nxt_pos[3:0]];
            end else begin
               serial_in_line <= (nxt_pos[7:4] > 4'h2) && !serial_in_line;
            end
         end
         if (!sclk_ff && serial_clk) begin
            shift_ff <= {shift_ff[14:0], serial_out_line};
            if (pos_ff[3:0] == 4'hF) begin
               rx[pos_ff[8:4]] <= {shift_ff[14:0], serial_out_line};
            end
         end
      end
   end
endmodule : tdm_link_partner
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// testbench
module tb_top;
   localparam logic [3:0] ID = 4'hA; // arbitrary value
   logic clk, rst, sin, sclk, fs, sout, soe, phi, plo, av, ar, dreq, dv;
   logic [15:0] cw;
   logic [3:0] bad [3] = '{4'hB, 4'hE, 4'hF};
   tdm_codec_pkg::sample_s as, ds;
   int fail_count, comparisons;
   time t0;
   tdm_codec_serial_port #(.CHIP_ID(ID)) dut (.clk(clk), .rst(rst), .serial_in_line(sin), .serial_clk(sclk),
      .frame_sync(fs), .serial_out_line(sout), .serial_out_oe(soe), .ext_ctrl_pin_hi(phi), .ext_ctrl_pin_lo(plo),
      .adc_sample(as), .adc_valid(av), .adc_ready(ar), .dac_req(dreq), .dac_sample(ds), .dac_valid(dv));
   tdm_link_partner peer (.clk(clk), .rst(rst), .serial_clk(sclk), .frame_sync(fs), .serial_out_line(sout),
      .ctrl_word(cw), .serial_in_line(sin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   // the word goes out from the next frame start; that frame is judged when it ends
   task automatic wr(input logic [15:0] w);
      @(posedge fs);
      #1 cw = w;
      @(posedge fs);
   endtask : wr
   task automatic per(input int n);
      @(posedge fs);
      t0 = $time;
      @(posedge fs);
      chk(32'(($time - t0) / 40), n);
   endtask : per
   task automatic dac(input logic [31:0] exp);
      @(posedge clk);
      #1 dreq = 1'b1;
      @(posedge clk);
      #1 dreq = 1'b0;
      chk(dv, 1'b1);
      chk(ds, exp);
   endtask : dac
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #3800000;
      fail_count++;
      report_and_stop();
   end
   // reserved control bits are always sent as zero
   initial begin
      rst = 1'b1;
      cw = 16'h0000;
      av = 1'b0;
      dreq = 1'b0;
      as = '0;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      chk({phi, plo}, 2'b00);
      wr(16'h0A80);
      chk({phi, plo}, 2'b10);
      foreach (bad[i]) begin
         wr({4'h2, bad[i], 8'hFF});
         chk(peer.rx[3], {4'h2, ID, 8'h00});
         chk(peer.rx[19], {4'h2, ID, 8'h00});
      end
      chk({phi, plo}, 2'b10);
      wr(16'h2C40);
      chk(peer.rx[3], 16'h2C00);
      per(4096);
      wr(16'h6C40);
      // new slot setup only shows from the frame after the write
      @(posedge fs);
      chk(peer.rx[0], 16'h6C40);
      wr(16'h6CC0);
      per(2048);
      wr(16'h0D01);
      @(posedge clk);
      #1 as = {16'h4000, 16'hC000};
      av = 1'b1;
      @(posedge clk);
      #1 av = 1'b0;
      repeat (2) @(posedge fs);
      chk({peer.rx[1], peer.rx[2]}, {16'h4000, 16'hC000});
      dac({16'h4000, 16'hC000});
      wr(16'h0D11);
      dac({16'h2000, 16'hE000});
      @(posedge clk);
      #1 av = 1'b1;
      repeat (8) @(posedge clk);
      // fifo is full now, so this value is offered only during overrun
      #1 as = 32'h12345678;
      repeat (2) @(posedge clk);
      #1 av = 1'b0;
      chk(ar, 1'b0);
      dac({16'h2000, 16'hE000});
      wr(16'h0D10);
      dac(32'h0);
      wr(16'h0000);
      chk(peer.rx[0], {4'h0, ID, 8'h01});
      report_and_stop();
   end
endmodule : tb_top
bind tdm_codec_serial_port tdm_codec_serial_port_props props (.clk(clk), .rst(rst), .serial_clk(serial_clk),
   .frame_sync(frame_sync), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
   .dac_req(dac_req), .dac_valid(dac_valid));
`default_nettype wire
